// >>> rtl/xqt_top.sv
// register front end of the extended query table
// assumes a single-cycle strobe master that never waits
`timescale 1ns/1ps
`default_nettype none

module xqt_top #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire xqt_pkg::xqt_addr_t reg_addr,
  input wire xqt_pkg::xqt_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output xqt_pkg::xqt_word_t reg_rdata,
  output logic query_active,
  output logic op_suspended
);
  import xqt_pkg::*;

  xqt_rom_if rom_if ();

  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] count_q;
  logic unmapped_q;
  xqt_word_t rdata_q;
  xqt_word_t rdata_d;
  logic [STAT_W-1:0] status;
  logic own_hit;
  logic table_rd;

  xqt_rom u_rom (
    .port(rom_if.rom)
  );

  assign rom_if.addr = reg_addr;
  assign own_hit = (reg_addr == OFS_CTRL) || (reg_addr == OFS_STATUS) || (reg_addr == OFS_QCOUNT);
  // suspend never gates the table, only query mode does
  assign table_rd = reg_rd && rom_if.hit && ctrl_q[CTRL_QUERY_BIT];
  assign status = {unmapped_q, ctrl_q[CTRL_SUSP_BIT], ctrl_q[CTRL_QUERY_BIT]};

  // control word: query mode and suspend state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (reg_wr && reg_addr == OFS_CTRL)
    begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  // table read counter; a read in the clearing cycle still counts
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= '0;
    end
    else if (table_rd)
    begin
      count_q <= count_q + CNT_W'(1);
    end
    else if (reg_wr && reg_addr == OFS_QCOUNT)
    begin
      count_q <= '0;
    end
  end

  // last read hit nothing mapped
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      unmapped_q <= 1'b0;
    end
    else if (reg_rd)
    begin
      unmapped_q <= !(own_hit || rom_if.hit);
    end
  end

  // read mux; the table is read-only and writes to it fall away
  always_comb
  begin
    rdata_d = '0;
    if (reg_addr == OFS_CTRL)
    begin
      rdata_d = xqt_word_t'(ctrl_q);
    end
    else if (reg_addr == OFS_STATUS)
    begin
      rdata_d = xqt_word_t'(status);
    end
    else if (reg_addr == OFS_QCOUNT)
    begin
      rdata_d = xqt_word_t'(count_q);
    end
    else if (rom_if.hit && ctrl_q[CTRL_QUERY_BIT])
    begin
      rdata_d = xqt_word_t'(rom_if.data);
    end
  end

  // answer stands one cycle only, zero otherwise
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
    end
    else if (reg_rd)
    begin
      rdata_q <= rdata_d;
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign query_active = ctrl_q[CTRL_QUERY_BIT];
  assign op_suspended = ctrl_q[CTRL_SUSP_BIT];

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!nrst);

  sequence tbl_rd_s(xqt_addr_t a);
    reg_rd && reg_addr == a && ctrl_q[CTRL_QUERY_BIT];
  endsequence

  sequence pair_rd_s(xqt_addr_t a, xqt_addr_t b);
    tbl_rd_s(a) ##1 tbl_rd_s(b);
  endsequence

  property tbl_byte_p(xqt_addr_t a, xqt_byte_t v);
    tbl_rd_s(a) |=> reg_rdata == {8'h00, v};
  endproperty

  sig_byte0_a: assert property (tbl_byte_p(8'h39, 8'h50))
    else $error("signature byte 0 wrong");
  sig_byte1_a: assert property (tbl_byte_p(8'h3a, 8'h52))
    else $error("signature byte 1 wrong");
  sig_byte2_a: assert property (tbl_byte_p(8'h3b, 8'h49))
    else $error("signature byte 2 wrong");
  sig_string_a: assert property (
    tbl_rd_s(8'h39) ##1 tbl_rd_s(8'h3a) ##1 tbl_rd_s(8'h3b)
    |=> reg_rdata[7:0] == 8'h49 && $past(reg_rdata[7:0]) == 8'h52
        && $past(reg_rdata[7:0], 2) == 8'h50)
    else $error("signature string out of order");

  ver_major_a: assert property (tbl_byte_p(8'h3c, 8'h31))
    else $error("major version wrong");
  ver_minor_a: assert property (tbl_byte_p(8'h3d, 8'h33))
    else $error("minor version wrong");

  feat_byte0_a: assert property (tbl_byte_p(8'h3e, 8'he6))
    else $error("feature byte 0 wrong");
  feat_byte1_a: assert property (tbl_byte_p(8'h3f, 8'h03))
    else $error("feature byte 1 wrong");
  feat_upper_a: assert property (
    tbl_rd_s(8'h3f) or tbl_rd_s(8'h40) or tbl_rd_s(8'h41) |=> reg_rdata[7:2] == 6'h00)
    else $error("reserved feature bits set");

  feat_more_a: assert property (tbl_rd_s(8'h41) |=> !reg_rdata[7])
    else $error("further feature field announced");

  feat_low_a: assert property (
    tbl_rd_s(OFS_FEAT0) |=> !reg_rdata[FEAT_CHIP_ERASE_BIT] && reg_rdata[FEAT_SUSP_ERASE_BIT]
      && reg_rdata[FEAT_SUSP_PROG_BIT] && !reg_rdata[FEAT_LEGACY_LOCK_BIT]
      && !reg_rdata[FEAT_QUEUED_ERASE_BIT])
    else $error("feature bits 0 to 4 wrong");

  feat_mid_a: assert property (
    pair_rd_s(8'h3e, 8'h3f) |=> reg_rdata[1:0] == 2'h3 && $past(reg_rdata[7:5]) == 3'h7)
    else $error("feature bits 5 to 9 not set");

  after_susp_a: assert property (tbl_byte_p(8'h42, 8'h01))
    else $error("after-suspend byte wrong");

  susp_served_a: assert property (
    tbl_rd_s(8'h39) and ctrl_q[CTRL_SUSP_BIT] |=> reg_rdata[7:0] == 8'h50 && reg_rdata != '0)
    else $error("table read refused during suspend");
  susp_status_a: assert property (
    reg_rd && reg_addr == OFS_STATUS && ctrl_q[CTRL_SUSP_BIT] |=> reg_rdata[1] && reg_rdata[2] == $past(unmapped_q))
    else $error("status read refused during suspend");
  susp_count_a: assert property (
    ctrl_q[CTRL_SUSP_BIT] && table_rd |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("suspended table read not counted");

  blk_mask_a: assert property (
    pair_rd_s(8'h43, 8'h44) |=> reg_rdata == 16'h0000 && $past(reg_rdata) == 16'h0003)
    else $error("block status mask wrong");

  logic_supply_a: assert property (tbl_byte_p(8'h45, 8'h18))
    else $error("logic supply level wrong");
  prog_supply_a: assert property (tbl_byte_p(8'h46, 8'hc0))
    else $error("program supply level wrong");
  prot_count_a: assert property (tbl_byte_p(8'h47, 8'h01))
    else $error("protection field count wrong");

  lock_addr_a: assert property (
    pair_rd_s(8'h48, 8'h49) |=> {reg_rdata[7:0], $past(reg_rdata[7:0])} == 16'h0080)
    else $error("lock byte address wrong");

  fact_exp_a: assert property (tbl_byte_p(8'h4a, 8'h03))
    else $error("factory byte exponent wrong");
  user_exp_a: assert property (tbl_byte_p(8'h4b, 8'h03))
    else $error("user byte exponent wrong");

  upper_lane_a: assert property (
    reg_rd && rom_if.hit |=> reg_rdata[15:8] == 8'h00)
    else $error("upper data lines driven for table byte");
  idle_zero_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside the answer cycle");
  query_off_a: assert property (
    reg_rd && rom_if.hit && !ctrl_q[CTRL_QUERY_BIT] |=> reg_rdata == '0 && count_q == $past(count_q))
    else $error("table visible outside query mode");
  count_clear_a: assert property (
    reg_wr && reg_addr == OFS_QCOUNT |=> count_q == '0)
    else $error("counter clear lost");
  unmapped_a: assert property (
    reg_rd && !(own_hit || rom_if.hit) |=> reg_rdata == '0 && unmapped_q)
    else $error("unmapped read not flagged");

endmodule // xqt_top

`default_nettype wire

// >>> shared/xqt_pkg.sv
// constants, types and field layout for the extended query table block
// assumes one 25 MHz clock and a plain word-wide register port
// Functional notes
// - Query addresses 39h, 3Ah and 3Bh return 50h, 52h and 49h, the ASCII signature that opens the table.
// - The table version reads as ASCII major 31h at 3Ch and ASCII minor 33h at 3Dh.
// - Addresses 3Eh to 41h return the feature field E6h, 03h, 00h, 00h, with bits 10 to 31 reading zero.
// - Feature bit 31 stays clear, so a host must not look for a further feature field.
// - Feature bits report no chip erase, erase suspend, program suspend, no legacy lock and no queued erase.
// - Feature bits 5 to 9 are set for block locking, protection bits, page reads, sync reads and simultaneous ops.
// - Address 42h returns 01h: program is allowed after erase suspend, other bits zero.
// - While an operation is suspended, reads of the status and the query table are still served.
// - Addresses 43h and 44h return the block status mask 03h, 00h with bits 2 to 15 zero.
// - Address 45h returns 18h, the best logic supply level as BCD volts and BCD tenths.
// - Address 46h returns C0h, the optimum programming supply as hex volts and BCD tenths.
// - Address 47h returns 01h protection fields, and a host reads 00h as 256 fields.
// - The lock byte sits at query address 0080h, low byte 80h at 48h and high byte 00h at 49h.
// - Addresses 4Ah and 4Bh each return exponent 03h, eight factory bytes and eight user bytes.

package xqt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CTRL_W = 2;
  localparam int STAT_W = 3;

  typedef logic [ADDR_W-1:0] xqt_addr_t;
  typedef logic [DATA_W-1:0] xqt_word_t;
  typedef logic [BYTE_W-1:0] xqt_byte_t;

  // own control and status words, below the table
  localparam xqt_addr_t OFS_CTRL = 8'h00;
  localparam xqt_addr_t OFS_STATUS = 8'h01;
  localparam xqt_addr_t OFS_QCOUNT = 8'h02;
  localparam int CTRL_QUERY_BIT = 0;
  localparam int CTRL_SUSP_BIT = 1;
  localparam int STAT_UNMAPPED_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

  // table offsets
  localparam xqt_addr_t OFS_SIG0 = 8'h39;
  localparam xqt_addr_t OFS_SIG1 = 8'h3a;
  localparam xqt_addr_t OFS_SIG2 = 8'h3b;
  localparam xqt_addr_t OFS_VER_MAJ = 8'h3c;
  localparam xqt_addr_t OFS_VER_MIN = 8'h3d;
  localparam xqt_addr_t OFS_FEAT0 = 8'h3e;
  localparam xqt_addr_t OFS_FEAT1 = 8'h3f;
  localparam xqt_addr_t OFS_FEAT2 = 8'h40;
  localparam xqt_addr_t OFS_FEAT3 = 8'h41;
  localparam xqt_addr_t OFS_AFTER_SUSP = 8'h42;
  localparam xqt_addr_t OFS_BLK_MASK_LO = 8'h43;
  localparam xqt_addr_t OFS_BLK_MASK_HI = 8'h44;
  localparam xqt_addr_t OFS_LOGIC_SUPPLY = 8'h45;
  localparam xqt_addr_t OFS_PROG_SUPPLY = 8'h46;
  localparam xqt_addr_t OFS_PROT_COUNT = 8'h47;
  localparam xqt_addr_t OFS_LOCK_LO = 8'h48;
  localparam xqt_addr_t OFS_LOCK_HI = 8'h49;
  localparam xqt_addr_t OFS_FACT_EXP = 8'h4a;
  localparam xqt_addr_t OFS_USER_EXP = 8'h4b;

  // feature field layout
  localparam int FEAT_CHIP_ERASE_BIT = 0;
  localparam int FEAT_SUSP_ERASE_BIT = 1;
  localparam int FEAT_SUSP_PROG_BIT = 2;
  localparam int FEAT_LEGACY_LOCK_BIT = 3;
  localparam int FEAT_QUEUED_ERASE_BIT = 4;
  localparam int FEAT_MORE_BIT = 31;
  localparam logic [31:0] FEATURE_WORD = 32'h0000_03e6;

  // table contents
  localparam xqt_byte_t VAL_SIG0 = 8'h50;
  localparam xqt_byte_t VAL_SIG1 = 8'h52;
  localparam xqt_byte_t VAL_SIG2 = 8'h49;
  localparam xqt_byte_t VAL_VER_MAJ = 8'h31;
  localparam xqt_byte_t VAL_VER_MIN = 8'h33;
  localparam xqt_byte_t VAL_FEAT0 = FEATURE_WORD[7:0];
  localparam xqt_byte_t VAL_FEAT1 = FEATURE_WORD[15:8];
  localparam xqt_byte_t VAL_FEAT2 = FEATURE_WORD[23:16];
  localparam xqt_byte_t VAL_FEAT3 = FEATURE_WORD[31:24];
  localparam xqt_byte_t VAL_AFTER_SUSP = 8'h01;
  localparam xqt_byte_t VAL_BLK_MASK_LO = 8'h03;
  localparam xqt_byte_t VAL_BLK_MASK_HI = 8'h00;
  localparam xqt_byte_t VAL_LOGIC_SUPPLY = 8'h18;
  localparam xqt_byte_t VAL_PROG_SUPPLY = 8'hc0;
  localparam xqt_byte_t VAL_PROT_COUNT = 8'h01;
  localparam xqt_byte_t VAL_LOCK_LO = 8'h80;
  localparam xqt_byte_t VAL_LOCK_HI = 8'h00;
  localparam xqt_byte_t VAL_FACT_EXP = 8'h03;
  localparam xqt_byte_t VAL_USER_EXP = 8'h03;

endpackage

// >>> shared/xqt_rom_if.sv
// lookup link between the register front end and the table
// assumes a purely combinational table behind the rom modport
`timescale 1ns/1ps
`default_nettype none

interface xqt_rom_if;
  xqt_pkg::xqt_addr_t addr;
  logic hit;
  xqt_pkg::xqt_byte_t data;

  modport user (output addr, input hit, input data);
  modport rom (input addr, output hit, output data);
endinterface

`default_nettype wire

// >>> rtl/xqt_rom.sv
// constant table of capability bytes, 39h to 4Bh
// assumes the caller registers the answer
`timescale 1ns/1ps
`default_nettype none

module xqt_rom (
  xqt_rom_if.rom port
);
  import xqt_pkg::*;

  always_comb
  begin
    port.hit = 1'b1;
    case (port.addr)
      OFS_SIG0: port.data = VAL_SIG0;
      OFS_SIG1: port.data = VAL_SIG1;
      OFS_SIG2: port.data = VAL_SIG2;
      OFS_VER_MAJ: port.data = VAL_VER_MAJ;
      OFS_VER_MIN: port.data = VAL_VER_MIN;
      OFS_FEAT0: port.data = VAL_FEAT0;
      OFS_FEAT1: port.data = VAL_FEAT1;
      OFS_FEAT2: port.data = VAL_FEAT2;
      OFS_FEAT3: port.data = VAL_FEAT3;
      OFS_AFTER_SUSP: port.data = VAL_AFTER_SUSP;
      OFS_BLK_MASK_LO: port.data = VAL_BLK_MASK_LO;
      OFS_BLK_MASK_HI: port.data = VAL_BLK_MASK_HI;
      OFS_LOGIC_SUPPLY: port.data = VAL_LOGIC_SUPPLY;
      OFS_PROG_SUPPLY: port.data = VAL_PROG_SUPPLY;
      OFS_PROT_COUNT: port.data = VAL_PROT_COUNT;
      OFS_LOCK_LO: port.data = VAL_LOCK_LO;
      OFS_LOCK_HI: port.data = VAL_LOCK_HI;
      OFS_FACT_EXP: port.data = VAL_FACT_EXP;
      OFS_USER_EXP: port.data = VAL_USER_EXP;
      default:
      begin
        port.hit = 1'b0;
        port.data = '0;
      end
    endcase
  end

endmodule // xqt_rom

`default_nettype wire

// >>> verification/xqt_host.sv
// host side bus master model for the query table front end
// assumes the slave answers a read in the next cycle and never stalls
`timescale 1ns/1ps
`default_nettype none

module xqt_host
  import xqt_pkg::*;
(
  input wire logic sys_clk,
  output xqt_pkg::xqt_addr_t reg_addr,
  output xqt_pkg::xqt_word_t reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire xqt_pkg::xqt_word_t reg_rdata
);
  xqt_word_t burst [19];

  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write strobe; data inverted afterwards so stale data never looks valid
  task automatic wr(input xqt_addr_t a, input xqt_word_t d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // read data only exist in the cycle after the strobe
  task automatic rd(input xqt_addr_t a, output xqt_word_t d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // back-to-back reads from a up, one strobe a cycle; answer k lands in burst[k-1]
  task automatic rd_run(input xqt_addr_t a, input int n);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    for (int k = 1; k <= n; k++)
    begin
      @(posedge sys_clk);
      reg_rd <= (k < n);
      reg_addr <= a + 8'(k);
      #1 burst[k-1] = reg_rdata;
    end
  endtask

  // a count of zero means the full 256 fields
  function automatic logic [8:0] field_count(input xqt_byte_t b);
    return (b == 8'h00) ? 9'd256 : {1'b0, b};
  endfunction

  // more feature fields only when the top bit is set
  function automatic logic more_fields(input logic [31:0] feat);
    return feat[31];
  endfunction
endmodule // xqt_host

`default_nettype wire

// >>> verification/xqt_top_test.sv
// self-checking bench for the query table front end
// assumes the host model as sole bus master and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module xqt_top_test;
  import xqt_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  xqt_addr_t reg_addr;
  xqt_word_t reg_wdata, reg_rdata, w;
  logic reg_wr, reg_rd, query_active, op_suspended;
  int num_errors = 0;
  int samples_checked = 0;
  logic [1:0] ctrl;
  xqt_byte_t got [19];
  localparam xqt_byte_t TBL [19] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'he6, 8'h03, 8'h00, 8'h00, 8'h01,
    8'h03, 8'h00, 8'h18, 8'hc0, 8'h01, 8'h80, 8'h00, 8'h03, 8'h03};

  always #20 sys_clk = ~sys_clk;

  xqt_top #(.CNT_W(16)) i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .query_active(query_active),
    .op_suspended(op_suspended));

  xqt_host i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // table byte on the low lane, upper lane zero; table hidden outside query mode
  function automatic xqt_word_t exp_word(input xqt_addr_t a, input logic [1:0] c);
    if (a == OFS_CTRL)
      return {14'h0000, c};
    if (a >= 8'h39 && a <= 8'h4b && c[0])
      return {8'h00, TBL[a - 8'h39]};
    return 16'h0000;
  endfunction

  task automatic rdc(input string nm, input xqt_addr_t a, input xqt_word_t e);
    i_host.rd(a, w);
    `CHK(nm, e, w)
  endtask

  task automatic wctrl(input logic [1:0] c);
    i_host.wr(OFS_CTRL, {14'h0000, c});
    ctrl = c;
    #1;
    `CHK("query mode", c[0], query_active)
    `CHK("suspend", c[1], op_suspended)
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // whole run needs about 260 cycles; reaching the 20000-cycle limit is a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    logic [31:0] feat;
    xqt_addr_t a;
    xqt_word_t d;
    void'($urandom(36122));
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    #1;
    `CHK("query mode after reset", 1'b0, query_active)
    `CHK("suspend after reset", 1'b0, op_suspended)
    `CHK("idle read data", 16'h0000, reg_rdata)
    rdc("ctrl reset", OFS_CTRL, 16'h0000);
    $display("test reset done");

    // full table walk, counted only in query mode
    i_host.wr(OFS_QCOUNT, 16'h0000);
    ctrl = 2'h0;
    rdc("table hidden", OFS_SIG1, 16'h0000);
    wctrl(2'h1);
    for (int i = 0; i < 19; i++)
    begin
      i_host.rd(8'h39 + i[7:0], w);
      got[i] = w[7:0];
      `CHK("table word", {8'h00, TBL[i]}, w)
    end
    rdc("read count", OFS_QCOUNT, 16'd19);
    // strobes with no gap, so the multi-byte field checks see neighbours
    i_host.rd_run(8'h39, 19);
    for (int i = 0; i < 19; i++)
      `CHK("burst word", {8'h00, TBL[i]}, i_host.burst[i])
    `CHK("zero field count", 9'd256, i_host.field_count(8'h00))
    feat = {got[8], got[7], got[6], got[5]};
    `CHK("feature field", 32'h0000_03e6, feat)
    `CHK("more fields", 1'b0, i_host.more_fields(feat))
    `CHK("lock address", 16'h0080, {got[16], got[15]})
    `CHK("field count", 9'd1, i_host.field_count(got[14]))
    `CHK("factory bytes", 9'd8, 9'd1 << got[17][3:0])
    `CHK("user bytes", 9'd8, 9'd1 << got[18][3:0])
    $display("test table done");

    // suspended: query table and status reads still served
    wctrl(2'h3);
    rdc("status suspended", OFS_STATUS, 16'h0003);
    rdc("version suspended", OFS_VER_MAJ, 16'h0031);
    rdc("after suspend", OFS_AFTER_SUSP, 16'h0001);
    rdc("unmapped", 8'h90, 16'h0000);
    rdc("status unmapped", OFS_STATUS, 16'h0007);
    rdc("signature", OFS_SIG2, 16'h0049);
    rdc("signature suspended", OFS_SIG0, 16'h0050);
    rdc("status mapped", OFS_STATUS, 16'h0003);
    $display("test suspend done");

    // random traffic; writes to table places must change nothing
    for (int n = 0; n < 80; n++)
    begin
      a = $urandom_range(0, 255);
      if (a == OFS_STATUS || a == OFS_QCOUNT)
        a = 8'h3e;
      if (n % 7 == 0)
        a = 8'h39 + 8'($urandom_range(0, 18));
      d = $urandom;
      if ($urandom_range(0, 3) == 0)
      begin
        if (a == OFS_CTRL)
          wctrl(d[1:0]);
        else
          i_host.wr(a, d);
      end
      else
        rdc("random read", a, exp_word(a, ctrl));
    end
    wctrl(2'h1);
    rdc("feature after writes", OFS_FEAT0, 16'h00e6);
    rdc("mask after writes", OFS_BLK_MASK_LO, 16'h0003);
    $display("test random done");
    finish_test();
  end
endmodule // xqt_top_test

`default_nettype wire
